// *** pkg/ccfr_pkg.sv ***
package ccfr_pkg;
  // widths
  localparam int TEMP_W = 12;
  localparam int REG_W = 8;
  // two-wire general call
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // configuration register 1 fields and power-on value
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_SD_BIT = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // status register fields and power-on value
  localparam int STATUS_OPEN_BIT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // temperature result power-on value
  localparam logic [11:0] TEMP_RESET = 12'h000;

  typedef enum logic [1:0] {
    CCFR_OFF,
    CCFR_WAIT_SUPPLY,
    CCFR_START,
    CCFR_CONVERT
  } ccfr_conv_t;

  typedef enum logic [2:0] {
    CCFR_GC_IDLE,
    CCFR_GC_ADDR,
    CCFR_GC_ACK1,
    CCFR_GC_DATA,
    CCFR_GC_ACK2,
    CCFR_GC_IGNORE
  } ccfr_gc_t;
endpackage

// *** src/ccfr_core.sv ***
`timescale 1ns/1ps
module ccfr_core (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // configuration register 1 write port
  input wire logic cfg_wr_en,
  input wire logic [ccfr_pkg::REG_W-1:0] cfg_wr_data,
  // status read with clear of sticky flags
  input wire logic status_rd_clr,
  // two-wire pins, sda open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  // analog comparators, asynchronous
  input wire logic diode_fault_comp,
  input wire logic supply_valid_comp,
  // converter handshake, same clock
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [ccfr_pkg::TEMP_W-1:0] adc_result,
  // limit comparison results, same clock
  input wire logic alert_limit_cond,
  input wire logic thermal_limit_cond,
  // alarm pins, open drain, enable high pulls low
  output logic early_warning_alarm_oe,
  output logic thermal_alarm_pin_oe,
  // state and results
  output logic analog_power_en,
  output logic soft_reset,
  output logic [ccfr_pkg::REG_W-1:0] cfg_out,
  output logic [ccfr_pkg::REG_W-1:0] status_out,
  output logic [ccfr_pkg::TEMP_W-1:0] temp_result
);
  import ccfr_pkg::*;

  // input synchronisers
  logic [1:0] scl_sync_reg, sda_sync_reg, fault_sync_reg, supply_sync_reg;
  logic scl_d_reg, sda_d_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      fault_sync_reg <= 2'h0;
      supply_sync_reg <= 2'h0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      fault_sync_reg <= {fault_sync_reg[0], diode_fault_comp};
      supply_sync_reg <= {supply_sync_reg[0], supply_valid_comp};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end

  logic scl_s, sda_s, fault_s, supply_ok;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign fault_s = fault_sync_reg[1];
  assign supply_ok = supply_sync_reg[1];

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // general call receiver
  ccfr_gc_t gc_state_reg, gc_state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic sda_oe_reg, sda_oe_next;
  logic rst_pend_reg, rst_pend_next;
  logic soft_reset_reg, soft_reset_next;

  always_comb begin
    gc_state_next = gc_state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    sda_oe_next = sda_oe_reg;
    rst_pend_next = rst_pend_reg;
    soft_reset_next = 1'b0;
    if (bus_stop) begin
      gc_state_next = CCFR_GC_IDLE;
      sda_oe_next = 1'b0;
      rst_pend_next = 1'b0;
      soft_reset_next = rst_pend_reg;
    end else if (bus_start) begin
      gc_state_next = CCFR_GC_ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_next = 1'b0;
      rst_pend_next = 1'b0;
    end else begin
      case (gc_state_reg)
        CCFR_GC_ADDR, CCFR_GC_DATA: begin
          if (scl_rise && bit_cnt_reg != BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            if (gc_state_reg == CCFR_GC_ADDR) begin
              if (shift_reg == GC_ADDR_BYTE) begin
                gc_state_next = CCFR_GC_ACK1;
                sda_oe_next = 1'b1;
              end else begin
                gc_state_next = CCFR_GC_IGNORE;
              end
            end else begin
              gc_state_next = CCFR_GC_ACK2;
              sda_oe_next = 1'b1;
              rst_pend_next = (shift_reg == GC_RESET_CMD);
            end
          end
        end
        CCFR_GC_ACK1: begin
          if (scl_fall) begin
            gc_state_next = CCFR_GC_DATA;
            sda_oe_next = 1'b0;
            bit_cnt_next = 4'h0;
          end
        end
        CCFR_GC_ACK2: begin
          if (scl_fall) begin
            gc_state_next = CCFR_GC_IGNORE;
            sda_oe_next = 1'b0;
          end
        end
        CCFR_GC_IDLE, CCFR_GC_IGNORE: begin
          sda_oe_next = 1'b0;
        end
        default: begin
          gc_state_next = CCFR_GC_IDLE;
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  // the serial interface stays on a plain reset so shutdown never touches it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gc_state_reg <= CCFR_GC_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      rst_pend_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
    end else begin
      gc_state_reg <= gc_state_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      sda_oe_reg <= sda_oe_next;
      rst_pend_reg <= rst_pend_next;
      soft_reset_reg <= soft_reset_next;
    end
  end

  // configuration and status registers
  logic [7:0] cfg_reg, cfg_next, status_reg, status_next;
  logic shutdown_request_bit, alarm_mask;
  assign shutdown_request_bit = cfg_reg[CFG_SD_BIT];
  assign alarm_mask = cfg_reg[CFG_MASK_BIT];

  // conversion sequencer
  ccfr_conv_t conv_state_reg, conv_state_next;
  logic fault_seen_reg, fault_seen_next;
  logic adc_start_reg, adc_start_next;
  logic power_reg, power_next;
  logic [11:0] temp_reg, temp_next;
  logic open_set;

  always_comb begin
    conv_state_next = conv_state_reg;
    fault_seen_next = fault_seen_reg;
    adc_start_next = 1'b0;
    temp_next = temp_reg;
    open_set = 1'b0;
    if (soft_reset_reg) begin
      conv_state_next = CCFR_OFF;
      fault_seen_next = 1'b0;
      temp_next = TEMP_RESET;
    end else if (shutdown_request_bit) begin
      conv_state_next = CCFR_OFF;
      fault_seen_next = 1'b0;
    end else begin
      case (conv_state_reg)
        CCFR_OFF: begin
          conv_state_next = CCFR_WAIT_SUPPLY;
        end
        CCFR_WAIT_SUPPLY: begin
          if (supply_ok) begin
            conv_state_next = CCFR_START;
          end
        end
        CCFR_START: begin
          adc_start_next = 1'b1;
          fault_seen_next = fault_s;
          conv_state_next = CCFR_CONVERT;
        end
        CCFR_CONVERT: begin
          if (!supply_ok) begin
            conv_state_next = CCFR_WAIT_SUPPLY;
          end else if (adc_done) begin
            if (fault_seen_reg || fault_s) begin
              open_set = 1'b1;
            end else begin
              temp_next = adc_result;
            end
            conv_state_next = CCFR_START;
          end else if (fault_s) begin
            fault_seen_next = 1'b1;
          end
        end
        default: begin
          conv_state_next = CCFR_OFF;
        end
      endcase
    end
    power_next = ~shutdown_request_bit & ~soft_reset_reg;
  end

  always_comb begin
    cfg_next = cfg_reg;
    status_next = status_reg;
    if (soft_reset_reg) begin
      cfg_next = CFG_RESET;
      status_next = STATUS_RESET;
    end else begin
      if (cfg_wr_en) begin
        cfg_next = cfg_wr_data;
      end
      if (status_rd_clr) begin
        status_next[STATUS_OPEN_BIT] = 1'b0;
      end
      // a fault in the clearing cycle survives
      if (open_set) begin
        status_next[STATUS_OPEN_BIT] = 1'b1;
      end
    end
  end

  // alarm pins
  logic ew_oe_reg, ew_oe_next, th_oe_reg, th_oe_next;
  always_comb begin
    if (soft_reset_reg) begin
      ew_oe_next = 1'b0;
      th_oe_next = 1'b0;
    end else begin
      ew_oe_next = ~alarm_mask & (status_next[STATUS_OPEN_BIT] | alert_limit_cond);
      th_oe_next = thermal_limit_cond;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_state_reg <= CCFR_OFF;
      fault_seen_reg <= 1'b0;
      adc_start_reg <= 1'b0;
      power_reg <= 1'b0;
      temp_reg <= TEMP_RESET;
      cfg_reg <= CFG_RESET;
      status_reg <= STATUS_RESET;
      ew_oe_reg <= 1'b0;
      th_oe_reg <= 1'b0;
    end else begin
      conv_state_reg <= conv_state_next;
      fault_seen_reg <= fault_seen_next;
      adc_start_reg <= adc_start_next;
      power_reg <= power_next;
      temp_reg <= temp_next;
      cfg_reg <= cfg_next;
      status_reg <= status_next;
      ew_oe_reg <= ew_oe_next;
      th_oe_reg <= th_oe_next;
    end
  end

  assign sda_oe = sda_oe_reg;
  assign adc_start = adc_start_reg;
  assign early_warning_alarm_oe = ew_oe_reg;
  assign thermal_alarm_pin_oe = th_oe_reg;
  assign analog_power_en = power_reg;
  assign soft_reset = soft_reset_reg;
  assign cfg_out = cfg_reg;
  assign status_out = status_reg;
  assign temp_result = temp_reg;
endmodule

// *** testbench/ccfr_sva.sv ***
`timescale 1ns/1ps
module ccfr_sva (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // inputs seen at the block
  input wire logic cfg_wr_en,
  input wire logic [ccfr_pkg::REG_W-1:0] cfg_wr_data,
  input wire logic supply_valid_comp,
  input wire logic adc_done,
  // block outputs
  input wire logic adc_start,
  input wire logic early_warning_alarm_oe,
  input wire logic thermal_alarm_pin_oe,
  input wire logic analog_power_en,
  input wire logic soft_reset,
  input wire logic [ccfr_pkg::REG_W-1:0] cfg_out,
  input wire logic [ccfr_pkg::REG_W-1:0] status_out,
  input wire logic [ccfr_pkg::TEMP_W-1:0] temp_result
);
  import ccfr_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_clr;
    cfg_out == CFG_RESET && status_out == STATUS_RESET && temp_result == TEMP_RESET
      && !early_warning_alarm_oe && !thermal_alarm_pin_oe;
  endsequence
  property p_sd_pwr; cfg_wr_en && cfg_wr_data[CFG_SD_BIT] && !soft_reset |-> ##2 !analog_power_en; endproperty
  property p_sd_stop; cfg_out[CFG_SD_BIT] && $past(cfg_out[CFG_SD_BIT], 2) |-> !adc_start; endproperty
  property p_b2b; adc_done && cfg_out == 8'h00 && supply_valid_comp && $past(supply_valid_comp, 4)
    && !soft_reset |-> ##[1:4] adc_start; endproperty
  property p_keep; $rose(status_out[STATUS_OPEN_BIT]) |-> $stable(temp_result); endproperty
  property p_open; status_out[STATUS_OPEN_BIT] && $past(status_out[STATUS_OPEN_BIT])
    && !cfg_out[CFG_MASK_BIT] && !$past(cfg_out[CFG_MASK_BIT]) |-> early_warning_alarm_oe; endproperty
  property p_supply; !supply_valid_comp [*6] |-> !adc_start && $stable(temp_result); endproperty
  property p_srst; soft_reset |=> s_clr; endproperty
  property p_pulse; soft_reset |=> !soft_reset; endproperty
  property p_mask; cfg_out[CFG_MASK_BIT] && $past(cfg_out[CFG_MASK_BIT]) |-> !early_warning_alarm_oe; endproperty
  a_sd_pwr: assert property (p_sd_pwr) else $error("power stays on in shutdown");
  a_sd_stop: assert property (p_sd_stop) else $error("conversion started in shutdown");
  a_b2b: assert property (p_b2b) else $error("no back to back conversion");
  a_keep: assert property (p_keep) else $error("result changed on fault");
  a_open: assert property (p_open) else $error("open flag without alarm");
  a_supply: assert property (p_supply) else $error("conversion on bad supply");
  a_srst: assert property (p_srst) else $error("soft reset left state");
  a_pulse: assert property (p_pulse) else $error("soft reset not one cycle");
  a_mask: assert property (p_mask) else $error("masked alarm active");
endmodule

// *** testbench/ccfr_host.sv ***
`timescale 1ns/1ps
module ccfr_host (
  // bench clock
  input wire logic clock,
  // two-wire lines, sda as resolved on the wire
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  import ccfr_pkg::*;
  initial begin
    scl = 1;
    sda_pull = 0;
  end
  // each bus phase lasts 5 clocks, above the sync minimum
  task automatic ph();
    repeat (5) @(posedge clock);
    #1;
  endtask
  // sda only moves while scl is low, so no false start or stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = !d[i];
      ph();
      scl = 1;
      ph();
      scl = 0;
      ph();
    end
    sda_pull = 0;
    ph();
    scl = 1;
    ph();
    ack = !sda;
    scl = 0;
    ph();
  endtask
  // start, general call address, one data byte, stop; returns at stop
  task automatic gc(input logic [7:0] d, output logic [1:0] ack);
    sda_pull = 1;
    ph();
    scl = 0;
    ph();
    wbyte(GC_ADDR_BYTE, ack[1]);
    wbyte(d, ack[0]);
    sda_pull = 1;
    ph();
    scl = 1;
    ph();
    sda_pull = 0;
  endtask
endmodule

// *** testbench/conversion_control_fault_reset_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module conversion_control_fault_reset_tb_top;
  import ccfr_pkg::*;
  logic clock = 0, reset_n = 0, cfg_wr_en = 0, status_rd_clr = 0, diode_fault_comp = 0, supply_valid_comp = 1;
  logic adc_done = 0, alert_limit_cond = 0, thermal_limit_cond = 0, scl, sda_pull, sda_oe, adc_start;
  logic early_warning_alarm_oe, thermal_alarm_pin_oe, analog_power_en, soft_reset;
  logic [7:0] cfg_wr_data = 8'h00, cfg_out, status_out;
  logic [11:0] adc_result = 12'h000, temp_result, t0, t1;
  logic [1:0] ack;
  logic [31:0] g_v, e_v, got_q[$], exp_q[$];
  int fail_count = 0, num_checks = 0, seed = 61001, cyc = 0, n;
  event seen;
  wire sda = !(sda_pull | sda_oe);
  always #50 clock = ~clock;
  ccfr_core uut (.clock, .reset_n, .cfg_wr_en, .cfg_wr_data, .status_rd_clr, .scl_in(scl), .sda_in(sda),
    .sda_oe, .diode_fault_comp, .supply_valid_comp, .adc_start, .adc_done, .adc_result, .alert_limit_cond,
    .thermal_limit_cond, .early_warning_alarm_oe, .thermal_alarm_pin_oe, .analog_power_en, .soft_reset,
    .cfg_out, .status_out, .temp_result);
  ccfr_host host (.clock, .sda, .scl, .sda_pull);
  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic sense(input logic [31:0] g, input logic [31:0] e);
    got_q.push_back(g); exp_q.push_back(e); -> seen;
  endtask
  always @(seen) while (got_q.size() > 0) begin
    g_v = got_q.pop_front(); e_v = exp_q.pop_front(); `CHK(g_v, e_v)
  end
  task automatic step(int k); repeat (k) @(posedge clock); #1; endtask
  task automatic wcfg(logic [7:0] d); cfg_wr_data = d; cfg_wr_en = 1; step(1); cfg_wr_en = 0; endtask
  task automatic wdone();
    n = 0;
    do @(posedge clock); while (adc_done !== 1'b1 && ++n < 300);
    if (n >= 300) fail_count++;
    t0 = adc_result; step(1);
  endtask
  // converter stand-in: random latency, random result
  always @(posedge clock) if (adc_start === 1'b1) begin
    step(2 + {$random(seed)} % 6);
    adc_result = 12'($random(seed)); thermal_limit_cond = 1'($random(seed)); adc_done = 1; step(1); adc_done = 0;
  end
  always @(posedge clock) if (++cyc == 20000) begin fail_count++; give_verdict(); end
  initial begin
    step(4);
    reset_n = 1;
    step(2);
    wcfg(8'h00);
    wdone();
    sense(temp_result, t0);
    t1 = temp_result;
    diode_fault_comp = 1;
    wdone();
    wdone();
    sense({status_out[STATUS_OPEN_BIT], early_warning_alarm_oe, temp_result}, {2'b11, t1});
    wcfg(8'h80);
    step(2);
    sense(early_warning_alarm_oe, 1'b0);
    wcfg(8'h00);
    diode_fault_comp = 0;
    wdone();
    wdone();
    status_rd_clr = 1;
    step(1);
    status_rd_clr = 0;
    wdone();
    sense({status_out, temp_result}, {8'h00, t0});
    supply_valid_comp = 0;
    step(5);
    t1 = temp_result;
    step(40);
    sense(temp_result, t1);
    supply_valid_comp = 1;
    step(20);
    wcfg(8'h40);
    step(2);
    t1 = temp_result;
    sense(analog_power_en, 1'b0);
    // both alarms active so the soft reset has something to release
    alert_limit_cond = 1;
    thermal_limit_cond = 1;
    host.gc(8'h05, ack);
    step(5);
    sense({ack, cfg_out}, {2'b11, 8'h40});
    sense({early_warning_alarm_oe, thermal_alarm_pin_oe, temp_result}, {2'b11, t1});
    host.gc(GC_RESET_CMD, ack);
    n = 0;
    do begin
      step(1);
    end while (soft_reset !== 1'b1 && ++n < 50);
    if (n >= 50) fail_count++;
    step(1);
    sense({ack, cfg_out, status_out, temp_result}, {2'b11, CFG_RESET, STATUS_RESET, TEMP_RESET});
    sense({early_warning_alarm_oe, thermal_alarm_pin_oe}, 2'b00);
    // let the checking process drain the queue before the verdict
    step(1);
    give_verdict();
  end
endmodule
bind ccfr_core ccfr_sva chk (.clock, .reset_n, .cfg_wr_en, .supply_valid_comp, .adc_start, .adc_done,
  .early_warning_alarm_oe, .thermal_alarm_pin_oe, .analog_power_en, .soft_reset, .cfg_wr_data, .cfg_out,
  .status_out, .temp_result);
